// ===== smc_host_model.sv
// Host stand-in: paces SPI words that flip the watchdog toggle bit.
// Assumes the bench drives run_in and gap_in; run_in low starves the watchdog.
`timescale 1ns/100ps
`default_nettype none
module smc_host_model (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic run_in,
  input wire logic [7:0] gap_in,
  output logic spi_word_stb_out = 1'b0,
  output logic [15:0] spi_word_out = 16'h5A5A
);
  logic [7:0] cnt_q = 8'h00;
  logic tog_q = 1'b0;
  // ====================
  // Word pacing
  // toggle bit
  always @(posedge mclk_in) begin
    if (rst_n_in && run_in && cnt_q >= gap_in) begin
      spi_word_stb_out <= 1'b1;
      spi_word_out <= {~tog_q, 15'h1234};
    end else begin
      spi_word_stb_out <= 1'b0;
      // Idle word lines keep moving so no stale value passes for data
      spi_word_out <= ~spi_word_out;
    end
    if (!rst_n_in) begin
      cnt_q <= 8'h00;
      tog_q <= 1'b0;
    end else if (run_in) begin
      if (cnt_q >= gap_in) begin
        cnt_q <= 8'h00;
        tog_q <= ~tog_q;
      end else begin
        cnt_q <= cnt_q + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ===== smc_mode_ctrl.sv
// Operating-mode controller of a dual high-side switch.
// Assumes all inputs synchronous to mclk_in; supply, fault and SPI word
// events come from neighbouring blocks as levels or one-cycle strobes.
//
// How it works
// - Normal flag only when wake, no failsafe/fault
// - Mode table: sleep, fault, failsafe outrank
// - Wake is reset pin OR activity flags
// - Failsafe from supply fail or watchdog
// - Fault is OR of protection faults
// - Target-on from direct input or PWM
// - Duty term from duty register bits
// - Direct control uses default delay, slew
// - External clock drives PWM, settings kept
// - Normal entry on reset rise or input
// - 250 ms input idle clears activity flag
// - Reset low or failsafe: direct inputs only
// - Watchdog disable bit at bit 4
// - Watchdog active: supply, enabled, reset high
// - Sleep: channels off, registers default
// - Sleep after power-up before activity
// - Failsafe entry: indicator low, resets, refuse
// - Watchdog starts on reset rise, checks bit
// - Failsafe exit needs two words in time
// - Return to normal: indicator high, resets
// - Fault indicator low while fault present and awake
`timescale 1ns/100ps
`default_nettype none

module smc_mode_ctrl
  import smc_pkg::*;
#(
  parameter int unsigned WDTO_CYC = SMC_WDTO_CYC,
  parameter int unsigned IDLE_CYC = SMC_IDLE_CYC
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  input wire logic device_reset_pin_in,
  input wire logic [1:0] direct_in,
  input wire logic logic_supply_ok_in,
  input wire logic [15:0] global_config_register_in,
  input wire logic logic_supply_fail_enable_in,
  input wire logic supply_high_fault_control_in,
  input wire logic spi_word_stb_in,
  input wire logic [15:0] spi_word_in,
  input wire logic [1:0] on_bit_in,
  input wire logic [1:0] direct_disable_in,
  input wire logic [1:0] pwm_enable_in,
  input wire logic [7:0] duty_setting_register0_in,
  input wire logic [7:0] duty_setting_register1_in,
  input wire logic [7:0] pwm_count0_in,
  input wire logic [7:0] pwm_count1_in,
  input wire logic [1:0] overcurrent_fault_in,
  input wire logic [1:0] overtemperature_fault_in,
  input wire logic [1:0] severe_short_fault_in,
  input wire logic under_supply_fault_in,
  input wire logic supply_high_fault_in,
  output logic [1:0] mode_out,
  output logic normal_mode_flag_out,
  output logic [1:0] target_on_out,
  output logic [1:0] direct_control_out,
  output logic failsafe_indicator_n_out,
  output logic fault_indicator_n_out,
  output logic reg_reset_out,
  output logic delatch_out,
  output logic spi_refuse_out,
  output logic spi_enable_out,
  output logic watchdog_active_out
);

  // ===========================================================
  // Elaboration checks
  if (WDTO_CYC < 2 || IDLE_CYC < 2) begin : g_bad_counts
    $error("timeout counts too small");
  end

  // ===========================================================
  // Combinational terms
  logic wake_up;
  logic fault_term;
  logic failsafe_term;
  logic wd_off;
  logic wd_timeout;
  smc_mode_t mode_q, mode_d;
  logic [1:0] duty_hit;
  logic [7:0] duty_val [2];
  logic [7:0] pwm_cnt [2];

  assign duty_val[0] = duty_setting_register0_in;
  assign duty_val[1] = duty_setting_register1_in;
  assign pwm_cnt[0] = pwm_count0_in;
  assign pwm_cnt[1] = pwm_count1_in;
  assign wd_off = global_config_register_in[SMC_WDOG_OFF_BIT];

  // ===========================================================
  // Per-channel activity and target-on
  logic [1:0] act_q, act_d;
  logic [1:0] in_prev_q, in_prev_d;
  logic [SMC_CNT_W-1:0] idle_q [2];
  logic [SMC_CNT_W-1:0] idle_d [2];
  logic [1:0] tgt_d;
  logic [1:0] dirc_d;
  logic rst_prev_q, rst_prev_d;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ch
      always_comb begin
        act_d[g] = act_q[g];
        idle_d[g] = idle_q[g];
        in_prev_d[g] = direct_in[g];
        if (direct_in[g] != in_prev_q[g] || direct_in[g]) begin
          act_d[g] = 1'b1;
          idle_d[g] = '0;
        end else if (idle_q[g] >= SMC_CNT_W'(IDLE_CYC - 1)) begin
          act_d[g] = 1'b0;
        end else begin
          idle_d[g] = idle_q[g] + SMC_CNT_W'(1);
        end
        // duty from bits 7..0; count below setting plus one
        duty_hit[g] = (pwm_cnt[g] <= duty_val[g][SMC_DUTY_W-1:0]);
        // direct only when reset low or failsafe
        dirc_d[g] = !device_reset_pin_in || mode_q == SMC_FAILSAFE;
        if (dirc_d[g]) begin
          tgt_d[g] = direct_in[g];
        end else begin
          // PWM count comes from whichever clock is selected
          tgt_d[g] = (direct_in[g] && !direct_disable_in[g])
                  || (on_bit_in[g] && duty_hit[g] && pwm_enable_in[g])
                  || (on_bit_in[g] && !pwm_enable_in[g]);
        end
      end
    end
  endgenerate

  // ===========================================================
  // Watchdog
  logic [SMC_CNT_W-1:0] wd_cnt_q, wd_cnt_d;
  logic wd_run_q, wd_run_d;
  logic wd_last_q, wd_last_d;
  logic wd_to_q, wd_to_d;
  logic wd_act;

  assign wd_act = logic_supply_ok_in && !wd_off && device_reset_pin_in;

  always_comb begin
    wd_cnt_d = wd_cnt_q;
    wd_run_d = wd_run_q;
    wd_last_d = wd_last_q;
    wd_to_d = wd_to_q;
    rst_prev_d = device_reset_pin_in;
    // Pin low or logic supply gone: a new start needs a fresh pin rise
    if (!logic_supply_ok_in || !device_reset_pin_in) begin
      wd_run_d = 1'b0;
      wd_cnt_d = '0;
      wd_to_d = 1'b0;
    end else if (device_reset_pin_in && !rst_prev_q) begin
      wd_run_d = 1'b1;
      wd_cnt_d = '0;
      wd_to_d = 1'b0;
    // disable bit parks the count but keeps the run armed
    end else if (wd_off) begin
      wd_cnt_d = '0;
      wd_to_d = 1'b0;
    end else if (wd_run_q) begin
      // first bit of each word checked
      if (spi_word_stb_in && spi_word_in[SMC_WORD_MSB] != wd_last_q) begin
        wd_last_d = spi_word_in[SMC_WORD_MSB];
        wd_cnt_d = '0;
        wd_to_d = 1'b0;
      end else if (wd_cnt_q >= SMC_CNT_W'(WDTO_CYC - 1)) begin
        wd_to_d = 1'b1;
      end else begin
        wd_cnt_d = wd_cnt_q + SMC_CNT_W'(1);
      end
    end
  end
  assign wd_timeout = wd_to_q;

  // ===========================================================
  // Failsafe exit handshake
  logic exit_arm_q, exit_arm_d;
  logic [SMC_CNT_W-1:0] exit_cnt_q, exit_cnt_d;
  logic exit_done;

  always_comb begin
    exit_arm_d = exit_arm_q;
    exit_cnt_d = exit_cnt_q;
    exit_done = 1'b0;
    if (mode_q != SMC_FAILSAFE) begin
      exit_arm_d = 1'b0;
      exit_cnt_d = '0;
    end else if (exit_arm_q) begin
      if (spi_word_stb_in) begin
        exit_done = 1'b1;
        exit_arm_d = 1'b0;
      end else if (exit_cnt_q >= SMC_CNT_W'(WDTO_CYC - 1)) begin
        exit_arm_d = 1'b0;
      end else begin
        exit_cnt_d = exit_cnt_q + SMC_CNT_W'(1);
      end
    // first word needs bit 15 set
    end else if (spi_word_stb_in && spi_word_in[SMC_WORD_MSB]) begin
      exit_arm_d = 1'b1;
      exit_cnt_d = '0;
    end
  end

  // ===========================================================
  // Mode selection
  logic fs_latch_q, fs_latch_d;

  always_comb begin
    wake_up = device_reset_pin_in || act_q[0] || act_q[1];
    fault_term = (|overcurrent_fault_in) || (|overtemperature_fault_in)
              || (|severe_short_fault_in) || under_supply_fault_in
              || (supply_high_fault_in && supply_high_fault_control_in);
    // failsafe cause; the latch holds it until the exit handshake or until sleep clears it
    failsafe_term = (!logic_supply_ok_in && logic_supply_fail_enable_in)
                 || (wd_timeout && !wd_off);
    fs_latch_d = fs_latch_q;
    // A cause still present in the exit cycle wins over the handshake
    if (!wake_up) begin
      fs_latch_d = 1'b0;
    end else if (failsafe_term) begin
      fs_latch_d = 1'b1;
    end else if (exit_done) begin
      fs_latch_d = 1'b0;
    end
    if (!wake_up) begin
      mode_d = SMC_SLEEP;
    end else if (fault_term) begin
      mode_d = SMC_FAULT;
    end else if (fs_latch_d) begin
      mode_d = SMC_FAILSAFE;
    end else begin
      mode_d = SMC_NORMAL;
    end
  end

  // ===========================================================
  // Registered outputs
  logic enter_fs;
  logic enter_normal;
  assign enter_fs = mode_d == SMC_FAILSAFE && mode_q != SMC_FAILSAFE;
  assign enter_normal = mode_d == SMC_NORMAL && mode_q != SMC_NORMAL;

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      mode_q <= SMC_SLEEP;
      act_q <= '0;
      in_prev_q <= '0;
      idle_q[0] <= '0;
      idle_q[1] <= '0;
      rst_prev_q <= 1'b0;
      wd_cnt_q <= '0;
      wd_run_q <= 1'b0;
      wd_last_q <= 1'b0;
      wd_to_q <= 1'b0;
      exit_arm_q <= 1'b0;
      exit_cnt_q <= '0;
      fs_latch_q <= 1'b0;
      mode_out <= 2'h0;
      normal_mode_flag_out <= 1'b0;
      target_on_out <= '0;
      direct_control_out <= '0;
      failsafe_indicator_n_out <= 1'b1;
      fault_indicator_n_out <= 1'b1;
      reg_reset_out <= 1'b1;
      delatch_out <= 1'b0;
      spi_refuse_out <= 1'b0;
      spi_enable_out <= 1'b0;
      watchdog_active_out <= 1'b0;
    end else if (clk_en_in) begin
      mode_q <= mode_d;
      act_q <= act_d;
      in_prev_q <= in_prev_d;
      idle_q[0] <= idle_d[0];
      idle_q[1] <= idle_d[1];
      rst_prev_q <= rst_prev_d;
      wd_cnt_q <= wd_cnt_d;
      wd_run_q <= wd_run_d;
      wd_last_q <= wd_last_d;
      wd_to_q <= wd_to_d;
      exit_arm_q <= exit_arm_d;
      exit_cnt_q <= exit_cnt_d;
      fs_latch_q <= fs_latch_d;
      mode_out <= mode_d;
      normal_mode_flag_out <= mode_d == SMC_NORMAL;
      // sleep and fault force channels off
      target_on_out <= (mode_d == SMC_NORMAL || mode_d == SMC_FAILSAFE) ? tgt_d : 2'h0;
      // direct control selects default delay and slew
      direct_control_out <= dirc_d;
      // indicator low in failsafe; high back in normal
      if (enter_fs) begin
        failsafe_indicator_n_out <= 1'b0;
      end else if (enter_normal) begin
        failsafe_indicator_n_out <= 1'b1;
      end
      fault_indicator_n_out <= !(wake_up && fault_term);
      // registers default in sleep; reset on failsafe and normal entry
      reg_reset_out <= mode_d == SMC_SLEEP || enter_fs || enter_normal;
      delatch_out <= enter_fs;
      spi_refuse_out <= fs_latch_d && mode_d != SMC_SLEEP;
      spi_enable_out <= mode_d != SMC_SLEEP && logic_supply_ok_in;
      watchdog_active_out <= wd_act && wd_run_d;
    end
  end

endmodule

`default_nettype wire

// ===== smc_mode_ctrl_asserts.sv
// Checker for the mode controller, bound onto its ports.
// Assumes clk_en_in stays high while checking.
`timescale 1ns/100ps
`default_nettype none
module smc_mode_ctrl_asserts
  import smc_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic device_reset_pin_in,
  input wire logic logic_supply_ok_in,
  input wire logic [15:0] global_config_register_in,
  input wire logic under_supply_fault_in,
  input wire logic supply_high_fault_in,
  input wire logic supply_high_fault_control_in,
  input wire logic [1:0] mode_out,
  input wire logic normal_mode_flag_out,
  input wire logic [1:0] target_on_out,
  input wire logic failsafe_indicator_n_out,
  input wire logic fault_indicator_n_out,
  input wire logic delatch_out,
  input wire logic watchdog_active_out
);
  default clocking @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n_in);
  // ====================
  // Mode relations
  sequence awake_under_s;
    device_reset_pin_in && under_supply_fault_in;
  endsequence
  sequence awake_high_s;
    device_reset_pin_in && supply_high_fault_in && supply_high_fault_control_in;
  endsequence
  flag_tracks_mode_a: assert property (
    normal_mode_flag_out == (mode_out == SMC_NORMAL))
    else $error("normal flag disagrees with mode");
  under_gives_fault_a: assert property (
    awake_under_s |=> mode_out == SMC_FAULT)
    else $error("undervoltage did not give fault mode");
  high_lowers_ind_a: assert property (
    awake_high_s |=> !fault_indicator_n_out)
    else $error("fault indicator high during overvoltage");
  pin_wakes_a: assert property (
    device_reset_pin_in |=> mode_out != SMC_SLEEP)
    else $error("sleep with reset pin high");
  sleep_off_a: assert property (
    mode_out == SMC_SLEEP && $past(mode_out) == SMC_SLEEP |-> target_on_out == 2'h0)
    else $error("channel on in sleep");
  fs_ind_low_a: assert property (
    mode_out == SMC_FAILSAFE |-> !failsafe_indicator_n_out)
    else $error("failsafe indicator high in failsafe");
  fs_ind_high_a: assert property (
    mode_out == SMC_NORMAL |-> failsafe_indicator_n_out)
    else $error("failsafe indicator low in normal");
  delatch_once_a: assert property (
    delatch_out |=> !delatch_out)
    else $error("delatch pulse too long");
  wd_gate_a: assert property (
    watchdog_active_out |-> $past(logic_supply_ok_in) && $past(device_reset_pin_in)
      && !$past(global_config_register_in[SMC_WDOG_OFF_BIT]))
    else $error("watchdog active while gated off");
endmodule
`default_nettype wire

// ===== smc_mode_ctrl_bench.sv
// Bench for the mode controller: channel case table, then mode tests.
// Assumes shortened watchdog and idle counts; clock enable held high.
`timescale 1ns/100ps
`default_nettype none
module smc_mode_ctrl_bench
  import smc_pkg::*;
;
  localparam int unsigned WDTO = 50;
  localparam int unsigned IDLE = 40;
  typedef struct packed {
    logic dir, dis, on, pen;
    logic [7:0] duty, cnt;
    logic exp;
  } smc_row_t;
  smc_row_t rows [8] = '{
    '{1'h1, 1'h0, 1'h0, 1'h0, 8'h00, 8'h00, 1'h1}, '{1'h1, 1'h1, 1'h0, 1'h0, 8'h00, 8'h00, 1'h0},
    '{1'h0, 1'h0, 1'h1, 1'h0, 8'h00, 8'h00, 1'h1}, '{1'h0, 1'h0, 1'h1, 1'h1, 8'h10, 8'h10, 1'h1},
    '{1'h0, 1'h0, 1'h1, 1'h1, 8'h10, 8'h11, 1'h0}, '{1'h0, 1'h0, 1'h0, 1'h1, 8'hFF, 8'h00, 1'h0},
    '{1'h0, 1'h0, 1'h1, 1'h1, 8'h00, 8'h00, 1'h1}, '{1'h1, 1'h1, 1'h1, 1'h1, 8'h00, 8'h01, 1'h0}};
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic device_reset_pin_in = 1'b0;
  logic supply_high_fault_control_in = 1'b1;
  logic run = 1'b0;
  logic supply_ok = 1'b1;
  logic fail_en = 1'b0;
  logic [7:0] gap = 8'h0A;
  logic [1:0] direct_in = 2'h0;
  logic [1:0] on_bit_in = 2'h0;
  logic [1:0] direct_disable_in = 2'h0;
  logic [1:0] pwm_enable_in = 2'h0;
  logic [15:0] global_config_register_in = 16'h0000;
  logic [7:0] duty = 8'h00;
  logic [7:0] cnt = 8'h00;
  logic [7:0] flt = 8'h00;
  logic stb;
  logic [15:0] word;
  logic [1:0] mode_out, target_on_out, direct_control_out;
  logic normal_mode_flag_out, failsafe_indicator_n_out, fault_indicator_n_out;
  logic reg_reset_out, delatch_out, spi_refuse_out, spi_enable_out, watchdog_active_out;
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0;
  int dl = 0;
  smc_host_model host (.mclk_in, .rst_n_in, .run_in(run), .gap_in(gap),
    .spi_word_stb_out(stb), .spi_word_out(word));
  smc_mode_ctrl #(.WDTO_CYC(WDTO), .IDLE_CYC(IDLE)) dut (.mclk_in, .rst_n_in,
    .clk_en_in(1'b1), .device_reset_pin_in, .direct_in, .logic_supply_ok_in(supply_ok),
    .global_config_register_in, .logic_supply_fail_enable_in(fail_en),
    .supply_high_fault_control_in,
    .spi_word_stb_in(stb), .spi_word_in(word), .on_bit_in, .direct_disable_in, .pwm_enable_in,
    .duty_setting_register0_in(duty), .duty_setting_register1_in(duty),
    .pwm_count0_in(cnt), .pwm_count1_in(cnt), .overcurrent_fault_in(flt[1:0]),
    .overtemperature_fault_in(flt[3:2]), .severe_short_fault_in(flt[5:4]),
    .under_supply_fault_in(flt[6]), .supply_high_fault_in(flt[7]), .mode_out,
    .normal_mode_flag_out, .target_on_out, .direct_control_out, .failsafe_indicator_n_out,
    .fault_indicator_n_out, .reg_reset_out, .delatch_out, .spi_refuse_out, .spi_enable_out,
    .watchdog_active_out);
  // ====================
  // Clock, timeout, pulse count
  initial begin
    forever #2.5 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (delatch_out === 1'b1)
      dl <= dl + 1;
    if (cyc == 3000) begin
      error_cnt++;
      final_report();
    end
  end
  task automatic final_report();
    if (error_cnt == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  task automatic chk(input string nm, input logic [1:0] e, input logic [1:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_mode(input smc_mode_t e);
    chk("mode", e, mode_out);
  endtask
  // ====================
  // Sequence
  initial begin
    wt(3);
    chk_mode(SMC_SLEEP);
    chk("regrst", 2'h1, {1'b0, reg_reset_out});
    repeat (13) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    wt(4);
    chk_mode(SMC_SLEEP);
    chk("spien", 2'h0, {1'b0, spi_enable_out});
    @(posedge mclk_in);
    // pin held high before inputs move
    device_reset_pin_in <= 1'b1;
    run <= 1'b1;
    wt(3);
    chk_mode(SMC_NORMAL);
    chk("normal_flag", 2'h1, {1'b0, normal_mode_flag_out});
    chk("wdact", 2'h1, {1'b0, watchdog_active_out});
    chk("spien", 2'h1, {1'b0, spi_enable_out});
    chk("regrst", 2'h0, {1'b0, reg_reset_out});
    foreach (rows[i]) begin
      @(posedge mclk_in);
      direct_in <= {2{rows[i].dir}};
      direct_disable_in <= {2{rows[i].dis}};
      on_bit_in <= {2{rows[i].on}};
      pwm_enable_in <= {2{rows[i].pen}};
      duty <= rows[i].duty;
      cnt <= rows[i].cnt;
      wt(2);
      chk("target", {2{rows[i].exp}}, target_on_out);
    end
    @(posedge mclk_in);
    direct_in <= 2'h0;
    direct_disable_in <= 2'h0;
    pwm_enable_in <= 2'h0;
    gap <= 8'h2D;
    wt(150);
    chk_mode(SMC_NORMAL);
    @(posedge mclk_in);
    global_config_register_in[SMC_WDOG_OFF_BIT] <= 1'b1;
    run <= 1'b0;
    wt(WDTO + 12);
    chk_mode(SMC_NORMAL);
    chk("wdact", 2'h0, {1'b0, watchdog_active_out});
    @(posedge mclk_in);
    run <= 1'b1;
    gap <= 8'h0A;
    wt(25);
    @(posedge mclk_in);
    global_config_register_in <= 16'h0000;
    for (int i = 0; i < 8; i++) begin
      @(posedge mclk_in);
      flt <= 8'h01 << i;
      wt(2);
      chk_mode(SMC_FAULT);
      chk("fault_ind", 2'h0, {1'b0, fault_indicator_n_out});
      chk("target", 2'h0, target_on_out);
      @(posedge mclk_in);
      flt <= 8'h00;
      wt(3);
      chk_mode(SMC_NORMAL);
    end
    @(posedge mclk_in);
    supply_high_fault_control_in <= 1'b0;
    flt <= 8'h80;
    wt(3);
    chk_mode(SMC_NORMAL);
    @(posedge mclk_in);
    flt <= 8'h00;
    run <= 1'b0;
    wt(WDTO + 12);
    chk_mode(SMC_FAILSAFE);
    chk("fs_ind", 2'h0, {1'b0, failsafe_indicator_n_out});
    chk("delatch", 2'h1, dl[1:0]);
    chk("refuse", 2'h1, {1'b0, spi_refuse_out});
    chk("target", 2'h0, target_on_out);
    chk("dirctl", 2'h3, direct_control_out);
    @(posedge mclk_in);
    direct_in <= 2'h3;
    wt(2);
    chk("target", 2'h3, target_on_out);
    @(posedge mclk_in);
    run <= 1'b1;
    wt(40);
    chk_mode(SMC_NORMAL);
    chk("fs_ind", 2'h1, {1'b0, failsafe_indicator_n_out});
    chk("refuse", 2'h0, {1'b0, spi_refuse_out});
    @(posedge mclk_in);
    fail_en <= 1'b1;
    supply_ok <= 1'b0;
    wt(3);
    chk_mode(SMC_FAILSAFE);
    chk("refuse", 2'h1, {1'b0, spi_refuse_out});
    chk("wdact", 2'h0, {1'b0, watchdog_active_out});
    @(posedge mclk_in);
    supply_ok <= 1'b1;
    wt(40);
    chk_mode(SMC_NORMAL);
    chk("fs_ind", 2'h1, {1'b0, failsafe_indicator_n_out});
    @(posedge mclk_in);
    device_reset_pin_in <= 1'b0;
    run <= 1'b0;
    direct_in <= 2'h0;
    wt(IDLE + 10);
    chk_mode(SMC_SLEEP);
    chk("regrst", 2'h1, {1'b0, reg_reset_out});
    chk("target", 2'h0, target_on_out);
    chk("spien", 2'h0, {1'b0, spi_enable_out});
    @(posedge mclk_in);
    direct_in <= 2'h1;
    wt(3);
    chk_mode(SMC_NORMAL);
    chk("dirctl", 2'h3, direct_control_out);
    final_report();
  end
endmodule
bind smc_mode_ctrl smc_mode_ctrl_asserts chk_i (.mclk_in, .rst_n_in, .device_reset_pin_in,
  .logic_supply_ok_in, .global_config_register_in, .under_supply_fault_in,
  .supply_high_fault_in, .supply_high_fault_control_in, .mode_out, .normal_mode_flag_out,
  .target_on_out, .failsafe_indicator_n_out, .fault_indicator_n_out, .delatch_out,
  .watchdog_active_out);
`default_nettype wire

// ===== smc_pkg.sv
// Constants and types shared by the switch operating-mode controller.
// Assumes a 200 MHz core clock; all timing counts derive from it.
package smc_pkg;

  // ===========================================================
  // Clock and timing
  localparam int unsigned SMC_CLK_MHZ = 200;
  localparam int unsigned SMC_WDTO_MS = 310;
  localparam int unsigned SMC_IDLE_MS = 250;
  localparam int unsigned SMC_CYC_PER_MS = SMC_CLK_MHZ * 1000;
  localparam int unsigned SMC_WDTO_CYC = SMC_WDTO_MS * SMC_CYC_PER_MS;
  localparam int unsigned SMC_IDLE_CYC = SMC_IDLE_MS * SMC_CYC_PER_MS;
  localparam int unsigned SMC_CNT_W = 32;

  // ===========================================================
  // Field positions
  localparam int unsigned SMC_WDOG_OFF_BIT = 4;
  localparam int unsigned SMC_GLOBAL_CFG_W = 16;
  localparam int unsigned SMC_DUTY_W = 8;
  localparam int unsigned SMC_WORD_MSB = 15;
  localparam logic [15:0] SMC_GLOBAL_CFG_RST = 16'h0000;
  localparam logic [7:0] SMC_DUTY_RST = 8'h00;
  localparam logic [1:0] SMC_DIRECT_SETTING = 2'h0;

  // ===========================================================
  // Operating modes
  typedef enum logic [1:0] {
    SMC_SLEEP,
    SMC_NORMAL,
    SMC_FAILSAFE,
    SMC_FAULT
  } smc_mode_t;

endpackage
